// ==== include/pmc_defs.svh ====
// register indices, field positions, reset values and timing for the phy mode block
// assumes a 100 MHz reference clock and 5-bit management register indices
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// register indices
`define PMC_IDX_SPECIAL     5'h12
`define PMC_IDX_TDR_PAT     5'h18
`define PMC_IDX_TDR_CTL     5'h19

// special configuration fields
`define PMC_FIBER_BIT       10
`define PMC_MODE_HI         7
`define PMC_MODE_LO         5
`define PMC_ADDR_HI         4
`define PMC_ADDR_LO         0

// cable test pattern and delay fields
`define PMC_DLY_BIT         15
`define PMC_BRK_HI          14
`define PMC_BRK_LO          12
`define PMC_PHI_HI          11
`define PMC_PHI_LO          6
`define PMC_PLO_HI          5
`define PMC_PLO_LO          0

// cable test control and result fields
`define PMC_TEN_BIT         15
`define PMC_FILT_BIT        14
`define PMC_TYPE_HI         10
`define PMC_TYPE_LO         9
`define PMC_STAT_BIT        8
`define PMC_LEN_HI          7
`define PMC_LEN_LO          0

// reset values
`define PMC_DLY_RST         1'h1
`define PMC_BRK_RST         3'h1
`define PMC_PHI_RST         6'h2e
`define PMC_PLO_RST         6'h1d
`define PMC_MODE_RST        3'h0
`define PMC_ADDR_RST        5'h00

// operating mode codes
`define PMC_MODE_10HD       3'h0
`define PMC_MODE_10FD       3'h1
`define PMC_MODE_100HD      3'h2
`define PMC_MODE_100FD      3'h3
`define PMC_MODE_AN100FD    3'h4
`define PMC_MODE_RSVD       3'h5
`define PMC_MODE_PWRDN      3'h6
`define PMC_MODE_ALL        3'h7

// cable type codes
`define PMC_CABLE_DEFAULT   2'h0
`define PMC_CABLE_SHORT     2'h1
`define PMC_CABLE_OPEN      2'h2
`define PMC_CABLE_MATCH     2'h3

// timing
`define PMC_CLK_MHZ         100
`define PMC_BREAK_BASE_US   2000
`define PMC_BREAK_STEP_US   256000
`define PMC_STRAP_SETTLE    2'h3

`endif

// ==== include/pmc_pkg.sv ====
// types shared by the phy mode and cable test register block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package pmc_pkg;

	// strap levels sampled at hardware reset
	typedef struct packed {
		logic       fiber;
		logic       autoneg;
		logic       speed;
		logic       duplex;
		logic [4:0] addr;
	} pmc_straps_t;

	// decoded operating mode handed to the transceiver
	typedef struct packed {
		logic power_down;
		logic autoneg_en;
		logic adv_all;
		logic speed_100;
		logic full_duplex;
		logic crs_on_tx;
	} pmc_mode_ctl_t;

	// cable test sequencer
	typedef enum logic [1:0] {
		PMC_ST_IDLE,
		PMC_ST_BREAK,
		PMC_ST_PULSE
	} pmc_test_st_t;

endpackage

`default_nettype wire

// ==== rtl/pmc_break_timer.sv ====
// line break timer for the cable test: base time plus optional 256 ms steps
// assumes start and cancel are single-cycle pulses on the same clock
`default_nettype none

module pmc_break_timer #(
	parameter int unsigned BASE_CYC = 200000,
	parameter int unsigned STEP_CYC = 25600000
) (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset,
	// control
	input  wire logic       i_start,
	input  wire logic       i_cancel,
	input  wire logic       i_extend,
	input  wire logic [2:0] i_steps,
	// status
	output var  logic       o_done
);

	logic [31:0] cnt_r;
	logic [2:0]  steps_r;
	logic        busy_r;
	logic        done_r;
	wire         cnt_zero = (cnt_r == 32'h0);
	wire         finish   = busy_r & cnt_zero & (steps_r == 3'h0);

	assign o_done = done_r;

	// base interval first, then one step interval per remaining count
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r   <= 32'h0;
			steps_r <= 3'h0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end else if (i_cancel) begin
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end else if (i_start) begin
			cnt_r   <= 32'(BASE_CYC - 1);
			steps_r <= i_extend ? i_steps : 3'h0;
			busy_r  <= 1'b1;
			done_r  <= 1'b0;
		end else begin
			done_r <= finish;
			if (finish) begin
				busy_r <= 1'b0;
			end else if (busy_r & cnt_zero) begin
				steps_r <= steps_r - 3'h1;
				cnt_r   <= 32'(STEP_CYC - 1);
			end else if (busy_r) begin
				cnt_r <= cnt_r - 32'h1;
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/pmc_regs.sv ====
// per-port phy special configuration and cable test registers
// assumes management accesses by register index on i_ref_clk, straps as raw pins
`include "pmc_defs.svh"
`default_nettype none

// Overview of operation
// - fiber bit defaults from this port's strap
// - mode defaults from autoneg, speed, duplex straps
// - fiber mode defaults to 100 fixed duplex
// - codes 000/001 are 10 Mb/s fixed
// - code 010 is 100 half, crs both
// - code 011 is 100 full, crs receive
// - code 100 advertises 100 full; 101 reserved
// - 110 power-down, 111 advertise all abilities
// - address field sets station id and seed
// - soft reset restores defaults when enabled
// - line break 2 ms unless delay set
// - break counter adds 256 ms steps
// - send high and low patterns during test
// - enable starts test, self-clears on completion
// - filter bit enables reflection data filtering
// - cable type reports default/short/open/match
// - length invalid when cable matched
module pmc_regs #(
	parameter bit          PORT_B         = 1'b0,
	parameter int unsigned BREAK_BASE_CYC = `PMC_BREAK_BASE_US * `PMC_CLK_MHZ,
	parameter int unsigned BREAK_STEP_CYC = `PMC_BREAK_STEP_US * `PMC_CLK_MHZ
) (
	// clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset,
	// configuration straps (pins)
	input  wire logic                  i_fiber_strap_port_a,
	input  wire logic                  i_fiber_strap_port_b,
	input  wire pmc_pkg::pmc_straps_t  i_straps,
	// soft reset from reset_control_reg and transceiver_basic_control
	input  wire logic                  i_phy_reset_pulse,
	input  wire logic                  i_transceiver_soft_reset,
	// management register access
	input  wire logic                  i_reg_rd,
	input  wire logic                  i_reg_wr,
	input  wire logic [4:0]            i_reg_idx,
	input  wire logic [15:0]           i_reg_wdata,
	output var  logic [15:0]           o_reg_rdata,
	output var  logic                  o_reg_ack,
	// measurement front end
	input  wire logic                  i_meas_done,
	input  wire logic [1:0]            i_meas_type,
	input  wire logic [7:0]            i_meas_len,
	// transceiver controls
	output var  pmc_pkg::pmc_mode_ctl_t o_mode_ctl,
	output var  logic                  o_fiber_mode,
	output var  logic [4:0]            o_management_station_id,
	output var  logic [4:0]            o_scrambler_seed,
	output var  logic                  o_line_break,
	output var  logic                  o_pulse_en,
	output var  logic [5:0]            o_pattern_high,
	output var  logic [5:0]            o_pattern_low,
	output var  logic                  o_filter_en
);

	// strap synchronisers and captured strap values
	pmc_pkg::pmc_straps_t s1_r, s2_r, s3_r, snap_r;
	pmc_pkg::pmc_straps_t strap_pin;
	logic [1:0]           settle_r;
	logic                 pending_r;
	logic                 load_r;

	// register fields
	logic                 fiber_select_r;
	logic [2:0]           mode_r;
	logic [4:0]           addr_r;
	logic                 dly_in_r;
	logic [2:0]           brk_r;
	logic [5:0]           pat_hi_r;
	logic [5:0]           pat_lo_r;
	logic                 ten_r;
	logic                 filt_r;
	logic [1:0]           type_r;
	logic                 stat_r;
	logic [7:0]           len_r;
	logic [15:0]          rdata_r;
	logic                 ack_r;
	pmc_pkg::pmc_mode_ctl_t mode_ctl_r;
	pmc_pkg::pmc_test_st_t  st_r;
	logic                 line_brk_r;
	logic                 pulse_r;
	logic                 brk_done;

	// pick this port's fiber strap in place of the shared one
	// per-port fiber strap
	always_comb begin
		strap_pin       = i_straps;
		strap_pin.fiber = PORT_B ? i_fiber_strap_port_b : i_fiber_strap_port_a;
	end

	// access decode
	wire wr_special = i_reg_wr & (i_reg_idx == `PMC_IDX_SPECIAL);
	wire wr_pat     = i_reg_wr & (i_reg_idx == `PMC_IDX_TDR_PAT);
	wire wr_ctl     = i_reg_wr & (i_reg_idx == `PMC_IDX_TDR_CTL);
	// restore only with soft reset bit set
	wire soft_restore = i_phy_reset_pulse & i_transceiver_soft_reset;
	wire apply      = load_r | soft_restore;
	wire strap_ok   = pending_r & (settle_r == `PMC_STRAP_SETTLE) & (s2_r == s3_r);

	// defaults from captured straps
	// fiber forces fixed 100 duplex code
	wire [2:0] mode_dflt = snap_r.fiber   ? {2'b01, snap_r.duplex} :
	                       snap_r.autoneg ? `PMC_MODE_ALL :
	                                        {1'b0, snap_r.speed, snap_r.duplex};

	// cable test events
	// writing one starts the test
	wire start     = wr_ctl & i_reg_wdata[`PMC_TEN_BIT] & ~ten_r;
	wire abort     = wr_ctl & ~i_reg_wdata[`PMC_TEN_BIT] & ten_r;
	wire test_done = (st_r == pmc_pkg::PMC_ST_PULSE) & i_meas_done;
	wire [7:0] len_cap = (i_meas_type == `PMC_CABLE_MATCH) ? 8'h00 : i_meas_len;

	// read words, reserved bits tied low
	// reserved bits read zero
	wire [15:0] rd_special = {5'h00, fiber_select_r, 2'h0, mode_r, addr_r};
	wire [15:0] rd_pat     = {dly_in_r, brk_r, pat_hi_r, pat_lo_r};
	wire [15:0] rd_ctl     = {ten_r, filt_r, 3'h0, type_r, stat_r, len_r};
	wire [15:0] rd_sel     = (i_reg_idx == `PMC_IDX_SPECIAL) ? rd_special :
	                         (i_reg_idx == `PMC_IDX_TDR_PAT) ? rd_pat :
	                         (i_reg_idx == `PMC_IDX_TDR_CTL) ? rd_ctl : 16'h0000;

	// mode decode
	// 10 Mb/s fixed codes
	// 100 half with crs on transmit
	pmc_pkg::pmc_mode_ctl_t mode_ctl_nxt;
	always_comb begin
		mode_ctl_nxt             = '0;
		mode_ctl_nxt.power_down  = (mode_r == `PMC_MODE_PWRDN);
		mode_ctl_nxt.autoneg_en  = (mode_r == `PMC_MODE_AN100FD) | (mode_r == `PMC_MODE_ALL);
		mode_ctl_nxt.adv_all     = (mode_r == `PMC_MODE_ALL);
		mode_ctl_nxt.speed_100   = (mode_r == `PMC_MODE_100HD) | (mode_r == `PMC_MODE_100FD) |
		                           (mode_r == `PMC_MODE_AN100FD);
		mode_ctl_nxt.full_duplex = (mode_r == `PMC_MODE_10FD) | (mode_r == `PMC_MODE_100FD) |
		                           (mode_r == `PMC_MODE_AN100FD);
		mode_ctl_nxt.crs_on_tx   = (mode_r == `PMC_MODE_100HD);
	end

	// strap pins pass three flops; first flop feeds only the second
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= strap_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// catch straps once after reset release, when the synchroniser agrees
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			pending_r <= 1'b1;
			settle_r  <= 2'h0;
			load_r    <= 1'b0;
			snap_r    <= '0;
		end else begin
			load_r <= strap_ok;
			if (pending_r & (settle_r != `PMC_STRAP_SETTLE))
				settle_r <= settle_r + 2'h1;
			if (strap_ok) begin
				pending_r <= 1'b0;
				snap_r    <= s3_r;
			end
		end
	end

	// special configuration register
	// station id and scrambler seed
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			fiber_select_r <= 1'b0;
			mode_r         <= `PMC_MODE_RST;
			addr_r         <= `PMC_ADDR_RST;
		end else if (apply) begin
			fiber_select_r <= snap_r.fiber;
			mode_r         <= mode_dflt;
			addr_r         <= snap_r.addr;
		end else if (wr_special) begin
			fiber_select_r <= i_reg_wdata[`PMC_FIBER_BIT];
			mode_r         <= i_reg_wdata[`PMC_MODE_HI:`PMC_MODE_LO];
			addr_r         <= i_reg_wdata[`PMC_ADDR_HI:`PMC_ADDR_LO];
		end
	end

	// pattern and delay register
	// pattern reset values
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			dly_in_r <= `PMC_DLY_RST;
			brk_r    <= `PMC_BRK_RST;
			pat_hi_r <= `PMC_PHI_RST;
			pat_lo_r <= `PMC_PLO_RST;
		end else if (apply) begin
			dly_in_r <= `PMC_DLY_RST;
			brk_r    <= `PMC_BRK_RST;
			pat_hi_r <= `PMC_PHI_RST;
			pat_lo_r <= `PMC_PLO_RST;
		end else if (wr_pat) begin
			dly_in_r <= i_reg_wdata[`PMC_DLY_BIT];
			brk_r    <= i_reg_wdata[`PMC_BRK_HI:`PMC_BRK_LO];
			pat_hi_r <= i_reg_wdata[`PMC_PHI_HI:`PMC_PHI_LO];
			pat_lo_r <= i_reg_wdata[`PMC_PLO_HI:`PMC_PLO_LO];
		end
	end

	// enable, filter and completion; completion wins over a clearing write
	// status held until restart or a control write with the status bit clear
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ten_r  <= 1'b0;
			filt_r <= 1'b0;
			stat_r <= 1'b0;
		end else if (apply) begin
			ten_r  <= 1'b0;
			filt_r <= 1'b0;
			stat_r <= 1'b0;
		end else begin
			if (wr_ctl)
				filt_r <= i_reg_wdata[`PMC_FILT_BIT];
			if (test_done | abort)
				ten_r <= 1'b0;
			else if (start)
				ten_r <= 1'b1;
			if (test_done)
				stat_r <= 1'b1;
			else if (start)
				stat_r <= 1'b0;
			else if (wr_ctl)
				stat_r <= stat_r & i_reg_wdata[`PMC_STAT_BIT];
		end
	end

	// results captured at completion
	// cable type capture
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			type_r <= `PMC_CABLE_DEFAULT;
			len_r  <= 8'h00;
		end else if (apply) begin
			type_r <= `PMC_CABLE_DEFAULT;
			len_r  <= 8'h00;
		end else if (test_done) begin
			type_r <= i_meas_type;
			len_r  <= len_cap;
		end
	end

	// sequencer: line break, then pulses until the front end reports
	// phase outputs are flops that move with the state, so pins never glitch
	// break before pulsing
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			st_r       <= pmc_pkg::PMC_ST_IDLE;
			line_brk_r <= 1'b0;
			pulse_r    <= 1'b0;
		end else if (apply | abort) begin
			st_r       <= pmc_pkg::PMC_ST_IDLE;
			line_brk_r <= 1'b0;
			pulse_r    <= 1'b0;
		end else begin
			unique case (st_r)
				pmc_pkg::PMC_ST_IDLE: if (start) begin
					st_r       <= pmc_pkg::PMC_ST_BREAK;
					line_brk_r <= 1'b1;
				end
				pmc_pkg::PMC_ST_BREAK: if (brk_done) begin
					st_r       <= pmc_pkg::PMC_ST_PULSE;
					line_brk_r <= 1'b0;
					pulse_r    <= 1'b1;
				end
				pmc_pkg::PMC_ST_PULSE: if (i_meas_done) begin
					st_r    <= pmc_pkg::PMC_ST_IDLE;
					pulse_r <= 1'b0;
				end
			endcase
		end
	end

	// break duration: base, plus steps when delay select is set
	// delay select extends
	pmc_break_timer #(
		.BASE_CYC (BREAK_BASE_CYC),
		.STEP_CYC (BREAK_STEP_CYC)
	) u_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_start   (start & ~apply),
		.i_cancel  (apply | abort),
		.i_extend  (dly_in_r),
		.i_steps   (brk_r),
		.o_done    (brk_done)
	);

	// registered read answer and decoded controls
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_r    <= 16'h0000;
			ack_r      <= 1'b0;
			mode_ctl_r <= '0;
		end else begin
			ack_r      <= i_reg_rd | i_reg_wr;
			mode_ctl_r <= mode_ctl_nxt;
			if (i_reg_rd)
				rdata_r <= rd_sel;
		end
	end

	// outputs straight from flops
	assign o_reg_rdata             = rdata_r;
	assign o_reg_ack               = ack_r;
	assign o_mode_ctl              = mode_ctl_r;
	assign o_fiber_mode            = fiber_select_r;
	assign o_management_station_id = addr_r;
	assign o_scrambler_seed        = addr_r;
	assign o_pattern_high          = pat_hi_r;
	assign o_pattern_low           = pat_lo_r;
	assign o_filter_en             = filt_r;
	assign o_line_break            = line_brk_r;
	assign o_pulse_en              = pulse_r;

	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	property p_fiber_dflt;
		apply |=> fiber_select_r == $past(snap_r.fiber);
	endproperty
	a_fiber_dflt: assert property (p_fiber_dflt) else $error("fiber default wrong");

	property p_mode_an;
		apply && !snap_r.fiber && snap_r.autoneg |=> mode_r == `PMC_MODE_ALL;
	endproperty
	a_mode_an: assert property (p_mode_an) else $error("autoneg default wrong");

	property p_mode_fiber;
		apply && snap_r.fiber |=> mode_r == {2'b01, $past(snap_r.duplex)};
	endproperty
	a_mode_fiber: assert property (p_mode_fiber) else $error("fiber mode default wrong");

	property p_crs_tx;
		mode_r == `PMC_MODE_100HD |=> o_mode_ctl.crs_on_tx && o_mode_ctl.speed_100 && !o_mode_ctl.full_duplex;
	endproperty
	a_crs_tx: assert property (p_crs_tx) else $error("100 half decode wrong");

	property p_pwrdn;
		mode_r == `PMC_MODE_PWRDN |=> o_mode_ctl.power_down && !o_mode_ctl.autoneg_en;
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("power-down decode wrong");

	property p_pat_rst;
		apply |=> pat_hi_r == `PMC_PHI_RST && pat_lo_r == `PMC_PLO_RST && brk_r == `PMC_BRK_RST;
	endproperty
	a_pat_rst: assert property (p_pat_rst) else $error("pattern defaults wrong");

	property p_selfclr;
		test_done && !apply |=> !ten_r && stat_r && !o_pulse_en;
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("enable not self-cleared");

	property p_start;
		start && !apply |=> ten_r && !stat_r && o_line_break;
	endproperty
	a_start: assert property (p_start) else $error("test start wrong");

	property p_stat_hold;
		stat_r && !apply && !start && !wr_ctl |=> stat_r;
	endproperty
	a_stat_hold: assert property (p_stat_hold) else $error("status dropped");

	property p_len_match;
		type_r == `PMC_CABLE_MATCH |-> len_r == 8'h00;
	endproperty
	a_len_match: assert property (p_len_match) else $error("length kept on match");

	property p_reserved;
		i_reg_rd && i_reg_idx == `PMC_IDX_SPECIAL |=> o_reg_rdata[15:11] == 5'h00 && o_reg_rdata[9:8] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule

`default_nettype wire

// ==== verif/pmc_meas_model.sv ====
// front end stand-in: answers a pulse phase with one measurement result
// assumes pulse enable is a level from the register block on the same clock
`default_nettype none

module pmc_meas_model (
	// clock
	input  wire logic       i_ref_clk,
	// test phase and chosen result
	input  wire logic       i_pulse_en,
	input  wire logic [1:0] i_type_sel,
	input  wire logic [7:0] i_len_sel,
	// result
	output var  logic       o_meas_done = 1'b0,
	output var  logic [1:0] o_meas_type = 2'h0,
	output var  logic [7:0] o_meas_len  = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r  = 4'h0;
	logic       fired_r = 1'b0;

	// one answer per phase; result lines toggle outside it so stale data never looks valid
	always @(posedge i_ref_clk) begin
		o_meas_done <= 1'b0;
		o_meas_type <= ~o_meas_type;
		o_meas_len  <= ~o_meas_len;
		if (!i_pulse_en) begin
			wait_r  <= 4'h0;
			fired_r <= 1'b0;
		end else if (!fired_r) begin
			if (wait_r == 4'h3) begin
				o_meas_done <= 1'b1;
				o_meas_type <= i_type_sel;
				o_meas_len  <= i_len_sel;
				fired_r     <= 1'b1;
			end else begin
				wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the phy mode and cable test registers
// assumes shortened break counts and a strobe-per-access management port
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned BASE = 20;
	localparam int unsigned STEP = 50;
	localparam logic [5:0] MC [8] = '{6'h00, 6'h02, 6'h05, 6'h06, 6'h16, 6'h00, 6'h20, 6'h18};

	logic                 i_ref_clk = 1'b0;
	logic                 i_reset   = 1'b1;
	logic                 fs_a      = 1'b0;
	logic                 fs_b      = 1'b0;
	pmc_pkg::pmc_straps_t straps    = '{1'b0, 1'b1, 1'b0, 1'b0, 5'h0a};
	logic                 prst      = 1'b0;
	logic                 srst      = 1'b0;
	logic                 rd        = 1'b0;
	logic                 wr        = 1'b0;
	logic [4:0]           idx       = 5'h00;
	logic [15:0]          wdata     = 16'h0000;
	logic [15:0]          rdata;
	logic                 ack;
	logic                 mdone;
	logic [1:0]           mtype;
	logic [7:0]           mlen;
	logic [1:0]           tsel      = 2'h0;
	logic [7:0]           lsel      = 8'h00;
	pmc_pkg::pmc_mode_ctl_t mctl;
	logic                 fib;
	logic [4:0]           sid;
	logic [4:0]           seed;
	logic                 lbrk;
	logic                 pen;
	logic [5:0]           phi;
	logic [5:0]           plo;
	logic                 filt;
	int                   n_mismatch = 0;
	int                   check_count = 0;
	int                   cyc = 0;
	logic [15:0]          v;
	int                   n;

	pmc_regs #(.PORT_B(1'b0), .BREAK_BASE_CYC(BASE), .BREAK_STEP_CYC(STEP)) pmc_regs_i (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_fiber_strap_port_a(fs_a),
		.i_fiber_strap_port_b(fs_b), .i_straps(straps), .i_phy_reset_pulse(prst),
		.i_transceiver_soft_reset(srst), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_idx(idx),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack), .i_meas_done(mdone),
		.i_meas_type(mtype), .i_meas_len(mlen), .o_mode_ctl(mctl), .o_fiber_mode(fib),
		.o_management_station_id(sid), .o_scrambler_seed(seed), .o_line_break(lbrk),
		.o_pulse_en(pen), .o_pattern_high(phi), .o_pattern_low(plo), .o_filter_en(filt));

	pmc_meas_model pmc_meas_model_i (.i_ref_clk(i_ref_clk), .i_pulse_en(pen), .i_type_sel(tsel),
		.i_len_sel(lsel), .o_meas_done(mdone), .o_meas_type(mtype), .o_meas_len(mlen));

	always #5 i_ref_clk = ~i_ref_clk;

	// hang guard well above the longest break plus accesses
	always @(posedge i_ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end

	task automatic complete_run();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// strobe one cycle; ack and data land after the taking edge
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		#1 rd = ~w;
		wr = w;
		idx = a;
		wdata = d;
		@(posedge i_ref_clk);
		#1 rd = 1'b0;
		wr = 1'b0;
		v = rdata;
		chk(16'(ack), 16'h1);
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk(v, e);
	endtask

	// hard reset with straps held stable through release and settle
	task automatic hard_reset(input logic fa, input logic dup);
		i_reset = 1'b1;
		fs_a = fa;
		straps.duplex = dup;
		straps.autoneg = ~fa;
		repeat (6) @(posedge i_ref_clk);
		#1 i_reset = 1'b0;
		repeat (8) @(posedge i_ref_clk);
	endtask

	// start a test, measure the break, wait for completion
	task automatic cable_test(input logic [15:0] ctl, input int exp_brk);
		acc(1'b1, 5'h19, ctl);
		n = 0;
		while (lbrk === 1'b1 && n < 3000) begin
			@(posedge i_ref_clk);
			#1 n = n + 1;
		end
		chk(16'(n >= exp_brk && n <= exp_brk + 3), 16'h1);
		n = 0;
		while (pen !== 1'b0 || n < 2) begin
			@(posedge i_ref_clk);
			#1 n = n + 1;
		end
	endtask

	initial begin
		hard_reset(1'b0, 1'b0);
		rdchk(5'h12, 16'h00ea);
		rdchk(5'h18, 16'h9b9d);
		rdchk(5'h19, 16'h0000);
		rdchk(5'h05, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, 5'h12, 16'hfb03 | 16'(i << 5));
			repeat (2) @(posedge i_ref_clk);
			#1 chk(16'(mctl & ((i == 7) ? 6'h38 : 6'h3f)), 16'(MC[i]));
			rdchk(5'h12, 16'h0003 | 16'(i << 5));
		end
		chk({6'h00, sid, seed}, 16'h0063);
		acc(1'b1, 5'h18, 16'h7fc0);
		chk({4'h0, phi, plo}, 16'h0fc0);
		tsel = 2'h2;
		lsel = 8'h10;
		cable_test(16'hc000, BASE);
		rdchk(5'h19, 16'h4510);
		chk(16'(filt), 16'h1);
		rdchk(5'h19, 16'h4510);
		acc(1'b1, 5'h18, 16'ha000);
		tsel = 2'h3;
		lsel = 8'h55;
		cable_test(16'h8000, BASE + 2 * STEP);
		rdchk(5'h19, 16'h0700);
		tsel = 2'h1;
		lsel = 8'h2c;
		acc(1'b1, 5'h18, 16'h0000);
		cable_test(16'h8000, BASE);
		rdchk(5'h19, 16'h032c);
		acc(1'b1, 5'h19, 16'h8000);
		acc(1'b0, 5'h19, 16'h0000);
		chk(v & 16'hc100, 16'h8000);
		acc(1'b1, 5'h19, 16'h0000);
		@(posedge i_ref_clk);
		#1 chk({14'h0, lbrk, pen}, 16'h0000);
		acc(1'b1, 5'h18, 16'h1234);
		@(posedge i_ref_clk);
		#1 prst = 1'b1;
		@(posedge i_ref_clk);
		#1 prst = 1'b0;
		rdchk(5'h18, 16'h1234);
		srst = 1'b1;
		@(posedge i_ref_clk);
		#1 prst = 1'b1;
		@(posedge i_ref_clk);
		#1 prst = 1'b0;
		srst = 1'b0;
		rdchk(5'h18, 16'h9b9d);
		rdchk(5'h12, 16'h00ea);
		// fiber strap of this port, duplex picks 011
		hard_reset(1'b1, 1'b1);
		rdchk(5'h12, 16'h046a);
		chk(16'(fib), 16'h1);
		acc(1'b1, 5'h12, 16'h0440);
		rdchk(5'h12, 16'h0440);
		// station id taken as written, no uniqueness check
		chk({6'h00, sid, seed}, 16'h0000);
		complete_run();
	end
endmodule

`default_nettype wire
